//--- ofs_pin_mux.sv
// one status terminal: picks a flag by its function code and registers it
`timescale 1ns/1ps
`default_nettype none

module ofs_pin_mux (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         arst_n_i,
  // selection
  input  wire logic [ofs_pkg::DIGIT_W-1:0]  code_i,
  input  wire logic [ofs_pkg::FLAG_N-1:0]   flags_i,
  // terminal
  output logic                              pin_o
);

  logic pin_r;

  // codes above nine cannot be stored, but stay quiet if one ever appears
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_r <= 1'b0;
    end else if (code_i <= ofs_pkg::DIGIT_MAX) begin
      pin_r <= flags_i[code_i];
    end else begin
      pin_r <= 1'b0;
    end
  end

  assign pin_o = pin_r;

endmodule
`default_nettype wire

//--- ofs_pin_select.sv
// status terminal function select with axi4-lite register access
//
// Functional notes
// - three decimal digits pick each terminal's function
// - digits map to pins one..three; reset 12
// - ten codes, zero to nine, any pin
// - code 0 follows alarms in the class set
// - code 1 at speed band, off decelerating
// - code 2 speed below low threshold
// - code 3 speed above detection threshold
// - code 4 run command, off during pre-excitation
// - code 5 torque or speed restriction acting
// - code 6 power dip or undervoltage alarm
// - code 7 panel operation, or open motor
// - code 8 torque above threshold
// - code 9 pre-excitation done, else output start
`timescale 1ns/1ps
`default_nettype none

module ofs_pin_select (
  // clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            arst_n_i,
  // axi4-lite write address
  input  wire logic [ofs_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr_i,
  input  wire logic                            s_axi_awvalid_i,
  output logic                                 s_axi_awready_o,
  // axi4-lite write data
  input  wire logic [ofs_pkg::AXI_DATA_W-1:0]  s_axi_wdata_i,
  input  wire logic [ofs_pkg::AXI_STRB_W-1:0]  s_axi_wstrb_i,
  input  wire logic                            s_axi_wvalid_i,
  output logic                                 s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]                           s_axi_bresp_o,
  output logic                                 s_axi_bvalid_o,
  input  wire logic                            s_axi_bready_i,
  // axi4-lite read address
  input  wire logic [ofs_pkg::AXI_ADDR_W-1:0]  s_axi_araddr_i,
  input  wire logic                            s_axi_arvalid_i,
  output logic                                 s_axi_arready_o,
  // axi4-lite read data
  output logic [ofs_pkg::AXI_DATA_W-1:0]       s_axi_rdata_o,
  output logic [1:0]                           s_axi_rresp_o,
  output logic                                 s_axi_rvalid_o,
  input  wire logic                            s_axi_rready_i,
  // drive conditions
  input  wire ofs_pkg::ofs_drive_type          drive_i,
  // status terminals, high turns the output transistor on
  output logic                                 status_pin_one_o,
  output logic                                 status_pin_two_o,
  output logic                                 status_pin_three_o,
  // interrupt
  output logic                                 irq_o
);

  localparam int CW = ofs_pkg::CODE_W;
  localparam int SW = ofs_pkg::SPEED_W;
  localparam int TW = ofs_pkg::TORQ_W;
  localparam int AW = ofs_pkg::ALARM_W;
  localparam int PN = ofs_pkg::PIN_N;
  localparam int FN = ofs_pkg::FLAG_N;

  // configuration registers
  logic [CW-1:0]  pin_function_code_r;
  logic [SW-1:0]  at_speed_band_r;
  logic [SW-1:0]  speed_high_threshold_r;
  logic [SW-1:0]  speed_low_threshold_r;
  logic [TW-1:0]  torque_threshold_r;
  logic [AW-1:0]  alarm_class_set_r;
  logic           open_motor_detect_select_r;
  logic [PN-1:0]  irq_stat_r;
  logic [PN-1:0]  irq_mask_r;
  logic           irq_r;

  // flags and terminals
  logic [FN-1:0]  flags_r;
  logic [PN-1:0]  pins;
  logic [PN-1:0]  pins_prev_r;

  // write channel state
  logic                        aw_hold_r;
  logic                        w_hold_r;
  logic [ofs_pkg::AXI_ADDR_W-1:0] aw_addr_r;
  logic [31:0]                 w_data_r;
  logic [3:0]                  w_strb_r;
  logic                        awready_r;
  logic                        wready_r;
  logic                        bvalid_r;
  logic [1:0]                  bresp_r;

  // read channel state
  logic                        arready_r;
  logic                        rvalid_r;
  logic [31:0]                 rdata_r;
  logic [1:0]                  rresp_r;

  // combinational helpers
  logic        aw_take;
  logic        w_take;
  logic        wr_fire;
  logic        aw_hold_nxt;
  logic        w_hold_nxt;
  logic [7:0]  wr_off;
  logic [31:0] wr_old;
  logic [31:0] wr_val;
  logic        code_ok;
  logic        wr_err;
  logic [7:0]  rd_off;
  logic [31:0] rd_data_c;
  logic        rd_err_c;
  logic [SW-1:0] speed_err;
  logic [PN-1:0] irq_set;
  logic [PN-1:0] irq_clr;

  // old register word with the strobed bytes replaced
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // write handshake: address and data taken in either order
  assign aw_take     = s_axi_awvalid_i && awready_r;
  assign w_take      = s_axi_wvalid_i && wready_r;
  assign wr_fire     = aw_hold_r && w_hold_r && !bvalid_r;
  assign aw_hold_nxt = (aw_hold_r && !wr_fire) || aw_take;
  assign w_hold_nxt  = (w_hold_r && !wr_fire) || w_take;
  assign wr_off      = {aw_addr_r[7:2], 2'h0};

  // strobed write value; status and mask merge into zero so w1c stays exact
  always_comb begin
    wr_old = 32'h0000_0000;
    unique case (wr_off)
      ofs_pkg::FUNC_CODE_OFF:   wr_old[CW-1:0] = pin_function_code_r;
      ofs_pkg::AT_SPEED_OFF:    wr_old[SW-1:0] = at_speed_band_r;
      ofs_pkg::SPEED_HIGH_OFF:  wr_old[SW-1:0] = speed_high_threshold_r;
      ofs_pkg::SPEED_LOW_OFF:   wr_old[SW-1:0] = speed_low_threshold_r;
      ofs_pkg::TORQUE_OFF:      wr_old[TW-1:0] = torque_threshold_r;
      ofs_pkg::ALARM_CLASS_OFF: wr_old[AW-1:0] = alarm_class_set_r;
      ofs_pkg::OPEN_MOTOR_OFF:  wr_old[0] = open_motor_detect_select_r;
      default:                  ;
    endcase
    wr_val = merge(wr_old, w_data_r, w_strb_r);
  end

  // a code is stored only if every digit is decimal
  always_comb begin
    code_ok = 1'b1;
    for (int d = 0; d < PN; d++) begin
      if (wr_val[d*4 +: 4] > ofs_pkg::DIGIT_MAX) begin
        code_ok = 1'b0;
      end
    end
  end

  // unmapped offsets and bad codes answer slverr and change nothing
  assign wr_err = (wr_off == ofs_pkg::FUNC_CODE_OFF) ? !code_ok :
                  (wr_off > ofs_pkg::IRQ_MASK_OFF); // map is dense up to the mask

  // write address and data capture
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awready_r <= !aw_hold_nxt;
      wready_r  <= !w_hold_nxt;
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (w_take) begin
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end
    end
  end

  // write response
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bvalid_r <= 1'b0;
      bresp_r  <= ofs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_err ? ofs_pkg::RESP_SLVERR : ofs_pkg::RESP_OKAY;
    end else if (s_axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_function_code_r        <= ofs_pkg::FUNC_CODE_RST;
      at_speed_band_r            <= ofs_pkg::AT_SPEED_RST;
      speed_high_threshold_r     <= ofs_pkg::SPEED_HIGH_RST;
      speed_low_threshold_r      <= ofs_pkg::SPEED_LOW_RST;
      torque_threshold_r         <= ofs_pkg::TORQUE_RST;
      alarm_class_set_r          <= ofs_pkg::ALARM_CLASS_RST;
      open_motor_detect_select_r <= 1'b0;
      irq_mask_r                 <= ofs_pkg::IRQ_MASK_RST;
    end else if (wr_fire && !wr_err) begin
      unique case (wr_off)
        ofs_pkg::FUNC_CODE_OFF:   pin_function_code_r <= wr_val[CW-1:0];
        ofs_pkg::AT_SPEED_OFF:    at_speed_band_r <= wr_val[SW-1:0];
        ofs_pkg::SPEED_HIGH_OFF:  speed_high_threshold_r <= wr_val[SW-1:0];
        ofs_pkg::SPEED_LOW_OFF:   speed_low_threshold_r <= wr_val[SW-1:0];
        ofs_pkg::TORQUE_OFF:      torque_threshold_r <= wr_val[TW-1:0];
        ofs_pkg::ALARM_CLASS_OFF: alarm_class_set_r <= wr_val[AW-1:0];
        ofs_pkg::OPEN_MOTOR_OFF:  open_motor_detect_select_r <= wr_val[0];
        ofs_pkg::IRQ_MASK_OFF:    irq_mask_r <= wr_val[PN-1:0];
        default:                  ;
      endcase
    end
  end

  // read address decode
  assign rd_off = {s_axi_araddr_i[7:2], 2'h0};

  always_comb begin
    rd_data_c = 32'h0000_0000;
    rd_err_c  = 1'b0;
    unique case (rd_off)
      ofs_pkg::FUNC_CODE_OFF:   rd_data_c[CW-1:0] = pin_function_code_r;
      ofs_pkg::AT_SPEED_OFF:    rd_data_c[SW-1:0] = at_speed_band_r;
      ofs_pkg::SPEED_HIGH_OFF:  rd_data_c[SW-1:0] = speed_high_threshold_r;
      ofs_pkg::SPEED_LOW_OFF:   rd_data_c[SW-1:0] = speed_low_threshold_r;
      ofs_pkg::TORQUE_OFF:      rd_data_c[TW-1:0] = torque_threshold_r;
      ofs_pkg::ALARM_CLASS_OFF: rd_data_c[AW-1:0] = alarm_class_set_r;
      ofs_pkg::OPEN_MOTOR_OFF:  rd_data_c[0] = open_motor_detect_select_r;
      ofs_pkg::FLAG_STAT_OFF: begin
        rd_data_c[FN-1:0] = flags_r;
        rd_data_c[ofs_pkg::FLAG_STAT_PIN_LSB +: PN] = pins;
      end
      ofs_pkg::IRQ_STAT_OFF:    rd_data_c[PN-1:0] = irq_stat_r;
      ofs_pkg::IRQ_MASK_OFF:    rd_data_c[PN-1:0] = irq_mask_r;
      default:                  rd_err_c = 1'b1;
    endcase
  end

  // read channel: one outstanding read, answered the cycle after the take
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= ofs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_data_c;
      rresp_r   <= rd_err_c ? ofs_pkg::RESP_SLVERR : ofs_pkg::RESP_OKAY;
    end else if (rvalid_r && s_axi_rready_i) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // speed error magnitude, unsigned so no wrap is possible
  assign speed_err = (drive_i.speed >= drive_i.speed_ref) ?
                     drive_i.speed - drive_i.speed_ref :
                     drive_i.speed_ref - drive_i.speed;

  // flag conditions, recomputed every cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_r <= '0;
    end else begin
      flags_r[ofs_pkg::FN_ALARM]  <= |(drive_i.alarm_vec & alarm_class_set_r);
      flags_r[ofs_pkg::FN_SPEED]  <= (speed_err <= at_speed_band_r) &&
                                     !drive_i.decel;
      flags_r[ofs_pkg::FN_LOW]    <= drive_i.speed < speed_low_threshold_r;
      flags_r[ofs_pkg::FN_ABOVE]  <= drive_i.speed > speed_high_threshold_r;
      flags_r[ofs_pkg::FN_RUN]    <= (drive_i.run_fwd || drive_i.run_rev) &&
                                     !drive_i.pre_excite;
      flags_r[ofs_pkg::FN_LIMIT]  <= drive_i.torque_limit || drive_i.speed_limit;
      flags_r[ofs_pkg::FN_DIP]    <= drive_i.power_dip || drive_i.undervolt;
      flags_r[ofs_pkg::FN_PANEL]  <= open_motor_detect_select_r ?
                                     drive_i.open_motor : drive_i.panel_mode;
      flags_r[ofs_pkg::FN_TORQUE] <= drive_i.torque > torque_threshold_r;
      flags_r[ofs_pkg::FN_READY]  <= drive_i.prime_used ?
                                     drive_i.prime_done : drive_i.output_start;
    end
  end

  // one selector per terminal; digit for pin one is the highest nibble
  for (genvar p = 0; p < PN; p++) begin : g_pin
    ofs_pin_mux u_mux (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .code_i   (pin_function_code_r[(PN-1-p)*4 +: 4]),
      .flags_i  (flags_r),
      .pin_o    (pins[p])
    );
  end

  // rising edge of any terminal is an interrupt event
  assign irq_set = pins & ~pins_prev_r;
  assign irq_clr = (wr_fire && wr_off == ofs_pkg::IRQ_STAT_OFF) ?
                   wr_val[PN-1:0] : '0;

  // sticky status, a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pins_prev_r <= '0;
      irq_stat_r  <= '0;
      irq_r       <= 1'b0;
    end else begin
      pins_prev_r <= pins;
      irq_stat_r  <= (irq_stat_r & ~irq_clr) | irq_set;
      irq_r       <= |(irq_stat_r & irq_mask_r);
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready_o    = awready_r;
  assign s_axi_wready_o     = wready_r;
  assign s_axi_bvalid_o     = bvalid_r;
  assign s_axi_bresp_o      = bresp_r;
  assign s_axi_arready_o    = arready_r;
  assign s_axi_rvalid_o     = rvalid_r;
  assign s_axi_rdata_o      = rdata_r;
  assign s_axi_rresp_o      = rresp_r;
  assign status_pin_one_o   = pins[0];
  assign status_pin_two_o   = pins[1];
  assign status_pin_three_o = pins[2];
  assign irq_o              = irq_r;

endmodule
`default_nettype wire

//--- ofs_pin_select_sva.sv
// assertion checker for the status terminal function select block
`timescale 1ns/1ps
`default_nettype none

module ofs_pin_select_sva (
  // clock and reset
  input wire logic                           clk_i,
  input wire logic                           arst_n_i,
  // register writes
  input wire logic [ofs_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic                           s_axi_awvalid_i,
  input wire logic                           s_axi_awready_o,
  input wire logic [ofs_pkg::AXI_DATA_W-1:0] s_axi_wdata_i,
  input wire logic                           s_axi_wvalid_i,
  input wire logic                           s_axi_wready_o,
  input wire logic [1:0]                     s_axi_bresp_o,
  input wire logic                           s_axi_bvalid_o,
  input wire logic                           s_axi_bready_i,
  // drive side and terminals
  input wire ofs_pkg::ofs_drive_type         drive_i,
  input wire logic                           status_pin_one_o,
  input wire logic                           status_pin_two_o,
  input wire logic                           status_pin_three_o,
  input wire logic                           irq_o
);
  logic [7:0]  adr_r;
  logic [31:0] dat_r;
  logic [11:0] code_r;
  logic [15:0] cls_r;
  logic        opn_r;
  logic [2:0]  msk_r;
  logic [2:0]  quiet_r;
  logic        ok;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // address and data of the write under way
  always_ff @(posedge clk_i) begin
    if (s_axi_awvalid_i && s_axi_awready_o) adr_r <= s_axi_awaddr_i;
    if (s_axi_wvalid_i && s_axi_wready_o) dat_r <= s_axi_wdata_i;
  end

  // shadow settings, only writes answered okay count
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      code_r <= ofs_pkg::FUNC_CODE_RST;
      cls_r  <= ofs_pkg::ALARM_CLASS_RST;
      opn_r  <= 1'b0;
      msk_r  <= ofs_pkg::IRQ_MASK_RST;
    end else if (s_axi_bvalid_o && s_axi_bready_i && s_axi_bresp_o == ofs_pkg::RESP_OKAY) begin
      if (adr_r == ofs_pkg::FUNC_CODE_OFF) code_r <= dat_r[11:0];
      if (adr_r == ofs_pkg::ALARM_CLASS_OFF) cls_r <= dat_r[15:0];
      if (adr_r == ofs_pkg::OPEN_MOTOR_OFF) opn_r <= dat_r[0];
      if (adr_r == ofs_pkg::IRQ_MASK_OFF) msk_r <= dat_r[2:0];
    end
  end

  // settle time after a write or reset, so pipelined pins have caught up
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) quiet_r <= 3'h0;
    else if (s_axi_awvalid_i) quiet_r <= 3'h0;
    else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
  end
  assign ok = (quiet_r == 3'h7);

  property p_rst;
    $rose(arst_n_i) |=> !status_pin_one_o && !status_pin_two_o && !status_pin_three_o;
  endproperty
  a_rst: assert property (p_rst) else $error("pin high right after reset");
  property p_run;
    ok && code_r[11:8] == 4'h4 |->
      status_pin_one_o == $past((drive_i.run_fwd | drive_i.run_rev) & !drive_i.pre_excite, 2);
  endproperty
  a_run: assert property (p_run) else $error("run function wrong on pin one");
  property p_limit;
    ok && code_r[7:4] == 4'h5 |->
      status_pin_two_o == $past(drive_i.torque_limit | drive_i.speed_limit, 2);
  endproperty
  a_limit: assert property (p_limit) else $error("limit function wrong on pin two");
  property p_dip;
    ok && code_r[3:0] == 4'h6 |->
      status_pin_three_o == $past(drive_i.power_dip | drive_i.undervolt, 2);
  endproperty
  a_dip: assert property (p_dip) else $error("supply dip wrong on pin three");
  property p_panel;
    ok && code_r[11:8] == 4'h7 |->
      status_pin_one_o == $past(opn_r ? drive_i.open_motor : drive_i.panel_mode, 2);
  endproperty
  a_panel: assert property (p_panel) else $error("panel function wrong on pin one");
  property p_ready;
    ok && code_r[7:4] == 4'h9 |-> status_pin_two_o ==
      $past(drive_i.prime_used ? drive_i.prime_done : drive_i.output_start, 2);
  endproperty
  a_ready: assert property (p_ready) else $error("ready function wrong on pin two");
  property p_alarm;
    ok && code_r[3:0] == 4'h0 |-> status_pin_three_o == $past(|(drive_i.alarm_vec & cls_r), 2);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm function wrong on pin three");
  property p_irq;
    ok && msk_r[0] && $rose(status_pin_one_o) |-> ##[0:3] irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt after pin one rose");
  property p_irq_off;
    ok && msk_r == 3'h0 |-> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt with all masked");
endmodule

bind ofs_pin_select ofs_pin_select_sva u_sva (
  .clk_i, .arst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .drive_i, .status_pin_one_o, .status_pin_two_o, .status_pin_three_o, .irq_o);
`default_nettype wire

//--- ofs_pkg.sv
// shared constants and carriers for the status terminal function select block
package ofs_pkg;

  // bus geometry
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_STRB_W = 4;

  // register byte offsets
  localparam logic [7:0] FUNC_CODE_OFF   = 8'h00;
  localparam logic [7:0] AT_SPEED_OFF    = 8'h04;
  localparam logic [7:0] SPEED_HIGH_OFF  = 8'h08;
  localparam logic [7:0] SPEED_LOW_OFF   = 8'h0C;
  localparam logic [7:0] TORQUE_OFF      = 8'h10;
  localparam logic [7:0] ALARM_CLASS_OFF = 8'h14;
  localparam logic [7:0] OPEN_MOTOR_OFF  = 8'h18;
  localparam logic [7:0] FLAG_STAT_OFF   = 8'h1C;
  localparam logic [7:0] IRQ_STAT_OFF    = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFF    = 8'h24;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // quantity widths
  localparam int SPEED_W = 16;
  localparam int TORQ_W  = 16;
  localparam int ALARM_W = 16;
  localparam int DIGIT_W = 4;
  localparam int PIN_N   = 3;
  localparam int FLAG_N  = 10;

  // function code field: digit for pin one sits highest
  localparam int CODE_W       = PIN_N * DIGIT_W;
  localparam logic [3:0] DIGIT_MAX = 4'h9;

  // function codes, also the bit positions of the flag vector
  localparam int FN_ALARM  = 0;
  localparam int FN_SPEED  = 1;
  localparam int FN_LOW    = 2;
  localparam int FN_ABOVE  = 3;
  localparam int FN_RUN    = 4;
  localparam int FN_LIMIT  = 5;
  localparam int FN_DIP    = 6;
  localparam int FN_PANEL  = 7;
  localparam int FN_TORQUE = 8;
  localparam int FN_READY  = 9;

  // flag status register layout: flags low, live pin levels above
  localparam int FLAG_STAT_PIN_LSB = 16;

  // reset values
  localparam logic [CODE_W-1:0]  FUNC_CODE_RST   = 12'h012;
  localparam logic [SPEED_W-1:0] AT_SPEED_RST    = 16'h000A;
  localparam logic [SPEED_W-1:0] SPEED_HIGH_RST  = 16'h0000;
  localparam logic [SPEED_W-1:0] SPEED_LOW_RST   = 16'h0000;
  localparam logic [TORQ_W-1:0]  TORQUE_RST      = 16'h0000;
  localparam logic [ALARM_W-1:0] ALARM_CLASS_RST = 16'hFFFF;
  localparam logic [PIN_N-1:0]   IRQ_MASK_RST    = 3'h0;

  // drive-side conditions, all on the control clock
  typedef struct packed {
    logic [ALARM_W-1:0] alarm_vec;    // active protective alarms
    logic [SPEED_W-1:0] speed;        // output speed
    logic [SPEED_W-1:0] speed_ref;    // commanded speed
    logic [TORQ_W-1:0]  torque;       // output torque
    logic               decel;        // decelerating
    logic               run_fwd;      // forward run command
    logic               run_rev;      // reverse run command
    logic               pre_excite;   // pre-excitation under way
    logic               prime_used;   // pre-excitation is performed
    logic               prime_done;   // pre-excitation completed
    logic               output_start; // output has started
    logic               torque_limit; // torque restriction acting
    logic               speed_limit;  // speed restriction acting
    logic               power_dip;    // instantaneous power failure alarm
    logic               undervolt;    // undervoltage alarm
    logic               panel_mode;   // panel operation selected
    logic               open_motor;   // open motor circuit detected
  } ofs_drive_type;

endpackage

//--- ofs_status_reader.sv
// external controller input reading the open collector status terminals
`timescale 1ns/1ps
`default_nettype none

module ofs_status_reader (
  // terminals, high means transistor conducting
  input  wire logic [2:0] pin_on_i,
  // line levels at the controller input
  output logic [2:0]      line_n_o
);
  // pull-up on each line: a conducting transistor pulls it low
  assign line_n_o = ~pin_on_i;
endmodule
`default_nettype wire

//--- test_output_terminal_function_select.sv
// self-checking bench for the status terminal function select block
`timescale 1ns/1ps
`default_nettype none

module test_output_terminal_function_select;
  logic clk_i = 1'b0, arst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdat;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [1:0] resp;
  ofs_pkg::ofs_drive_type drv = '0, dv;
  wire logic awready, wready, bvalid, arready, rvalid, p1, p2, p3, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0] line_n;
  int error_cnt = 0, checks = 0, cyc = 0;

  ofs_pin_select uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(1'b1), .drive_i(drv), .status_pin_one_o(p1), .status_pin_two_o(p2),
    .status_pin_three_o(p3), .irq_o(irq));
  ofs_status_reader reader (.pin_on_i({p1, p2, p3}), .line_n_o(line_n));

  // clock and hang guard
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // each channel released at its own handshake; bready and rready stay high
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      aw_ok = aw_ok | (awvalid & awready);
      w_ok = w_ok | (wvalid & wready);
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
    end
    do @(posedge clk_i); while (!bvalid);
    resp = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (!rvalid);
    rdat = rdata;
    resp = rresp;
  endtask

  // drive state making the flag of code c active or idle; speed 150 sits in no band
  task automatic mk(input logic [3:0] c, input logic on);
    dv = '0;
    dv.speed = 16'h0096;
    case (c)
      4'h0: dv.alarm_vec = {15'h0, on};
      4'h1: dv.speed_ref = on ? dv.speed : 16'h0000;
      4'h2: dv.speed = on ? 16'h0032 : 16'h0096;
      4'h3: dv.speed = on ? 16'h00FA : 16'h0096;
      4'h4: dv.run_fwd = on;
      4'h5: dv.torque_limit = on;
      4'h6: dv.power_dip = on;
      4'h7: dv.panel_mode = on;
      4'h8: dv.torque = on ? 16'h015E : 16'h00FA;
      default: dv.prime_done = on;
    endcase
    dv.prime_used = 1'b1;
  endtask

  // five edges: pins settle after two, the interrupt after four
  task automatic put();
    drv <= dv;
    repeat (5) @(posedge clk_i);
  endtask

  task automatic pc(input logic [31:0] exp);
    put();
    check({29'h0, p1, p2, p3}, exp);
  endtask

  task automatic sel(input logic [3:0] c, input logic on);
    wr(ofs_pkg::FUNC_CODE_OFF, {20'h0, c, c, c});
    mk(c, on);
  endtask

  task automatic t_reset();
    check({29'h0, p1, p2, p3}, 32'h0);
    rd(ofs_pkg::FUNC_CODE_OFF);
    check(rdat, 32'h012);
    $display("reset test done");
  endtask

  task automatic t_codes();
    wr(ofs_pkg::SPEED_LOW_OFF, 32'h64);
    wr(ofs_pkg::SPEED_HIGH_OFF, 32'hC8);
    wr(ofs_pkg::TORQUE_OFF, 32'h12C);
    for (int c = 0; c < 10; c++) begin
      sel(c[3:0], 1'b0);
      pc(32'h0);
      mk(c[3:0], 1'b1);
      pc(32'h7);
    end
    $display("code test done");
  endtask

  task automatic t_corner();
    sel(4'h1, 1'b1);
    dv.decel = 1'b1;
    pc(32'h0);
    sel(4'h4, 1'b1);
    dv.pre_excite = 1'b1;
    pc(32'h0);
    sel(4'h9, 1'b0);
    dv.prime_used = 1'b0;
    dv.output_start = 1'b1;
    pc(32'h7);
    sel(4'h6, 1'b0);
    dv.undervolt = 1'b1;
    pc(32'h7);
    sel(4'h5, 1'b0);
    dv.speed_limit = 1'b1;
    pc(32'h7);
    wr(ofs_pkg::ALARM_CLASS_OFF, 32'h2);
    sel(4'h0, 1'b1);
    pc(32'h0);
    wr(ofs_pkg::OPEN_MOTOR_OFF, 32'h1);
    sel(4'h7, 1'b1);
    pc(32'h0);
    dv.open_motor = 1'b1;
    pc(32'h7);
    wr(ofs_pkg::OPEN_MOTOR_OFF, 32'h0);
    wr(ofs_pkg::ALARM_CLASS_OFF, 32'hFFFF);
    $display("corner test done");
  endtask

  task automatic t_map();
    wr(ofs_pkg::FUNC_CODE_OFF, 32'h562);
    mk(4'h5, 1'b1);
    pc(32'h4);
    mk(4'h2, 1'b1);
    pc(32'h1);
    wr(ofs_pkg::FUNC_CODE_OFF, 32'h0A0);
    check({30'h0, resp}, {30'h0, ofs_pkg::RESP_SLVERR});
    rd(ofs_pkg::FUNC_CODE_OFF);
    check(rdat, 32'h562);
    rd(8'h30);
    check({30'h0, resp}, {30'h0, ofs_pkg::RESP_SLVERR});
    $display("map test done");
  endtask

  task automatic t_irq();
    wr(ofs_pkg::IRQ_MASK_OFF, 32'h1);
    sel(4'h4, 1'b0);
    put();
    wr(ofs_pkg::IRQ_STAT_OFF, 32'h7);
    repeat (8) @(posedge clk_i);
    check({31'h0, irq}, 32'h0);
    mk(4'h4, 1'b1);
    put();
    check({31'h0, irq}, 32'h1);
    check({29'h0, line_n}, 32'h0);
    rd(ofs_pkg::FLAG_STAT_OFF);
    check(rdat, 32'h00070010);
    rd(ofs_pkg::IRQ_STAT_OFF);
    check(rdat, 32'h7);
    wr(ofs_pkg::IRQ_STAT_OFF, 32'h1);
    repeat (3) @(posedge clk_i);
    check({31'h0, irq}, 32'h0);
    rd(ofs_pkg::IRQ_STAT_OFF);
    check(rdat, 32'h6);
    wr(ofs_pkg::IRQ_MASK_OFF, 32'h0);
    $display("interrupt test done");
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_codes();
    t_corner();
    t_map();
    t_irq();
    end_of_test();
  end
endmodule
`default_nettype wire
